/* core/fbe_erase_check.sv */
// Flash block-erase parameter check and result reporting sequencer.
// Assumes software loads the request fields before pulsing start.
`timescale 1ns/100ps
module fbe_erase_check (
  input  wire logic                 clk_sys_in,
  input  wire logic                 nrst_in,
  input  wire fbe_pkg::fbe_req_type req_in,
  output fbe_pkg::fbe_rsp_type      rsp_out,
  output logic                      erase_en_out,
  output logic [3:0]                erase_block_out,
  output logic                      block_erased_out
);
  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_ERASE, ST_DONE}
    fbe_state_type;

  fbe_state_type state_reg;
  fbe_state_type state_next;
  logic [7:0]    result_reg;
  logic [7:0]    result_next;
  logic [7:0]    index_reg;
  logic [15:0]   cnt_reg;
  logic          done_reg;
  logic          erase_en_reg;
  logic          busy_reg;
  logic          fail_seen_reg;

  // The upper 24 bits are ignored; only the low byte names the block.
  wire logic [7:0] block_index = req_in.block_select[7:0];
  wire logic range_err = index_reg > fbe_pkg::LAST_BLOCK;
  wire logic key_err = req_in.flash_key != fbe_pkg::KEY_UNLOCK;
  wire logic prot_err = req_in.error_protect_flag;
  wire logic boot_sel =
    req_in.array_select == fbe_pkg::ARRAY_SEL_USER_BOOT;
  wire logic pre_err = range_err | key_err | prot_err | boot_sel;
  wire logic cnt_last = cnt_reg == fbe_pkg::ERASE_CNT_LAST;

  always_comb begin
    state_next = state_reg;
    result_next = result_reg;
    case (state_reg)
      ST_IDLE: begin
        if (req_in.start) begin
          state_next = ST_CHECK;
          result_next = fbe_pkg::RESULT_CLEAR;
        end
      end
      ST_CHECK: begin
        result_next[fbe_pkg::RES_PROTECT_ERR_BIT] = prot_err;
        result_next[fbe_pkg::RES_EXEC_ERR_BIT] = boot_sel;
        result_next[fbe_pkg::RES_KEY_ERR_BIT] = key_err;
        result_next[fbe_pkg::RES_BLOCK_SEL_ERR_BIT] = range_err;
        result_next[fbe_pkg::RES_OVERALL_FAIL_BIT] = pre_err;
        state_next = pre_err ? ST_DONE : ST_ERASE;
      end
      ST_ERASE: begin
        if (cnt_last) begin
          state_next = ST_DONE;
          if (fail_seen_reg || req_in.settings_changed) begin
            result_next[fbe_pkg::RES_EXEC_ERR_BIT] = 1'b1;
            result_next[fbe_pkg::RES_OVERALL_FAIL_BIT] = 1'b1;
          end
        end
      end
      ST_DONE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    result_next[fbe_pkg::RES_UNUSED_TOP_BIT] = 1'b0;
    result_next[fbe_pkg::RES_UNUSED_HI_BIT] = 1'b0;
    result_next[fbe_pkg::RES_UNUSED_LO_BIT] = 1'b0;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      state_reg <= ST_IDLE;
      result_reg <= fbe_pkg::RESULT_CLEAR;
    end else begin
      state_reg <= state_next;
      result_reg <= result_next;
    end
  end

  // The index is latched once so a single block is named per request.
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      index_reg <= 8'h00;
    end else if (state_reg == ST_IDLE && req_in.start) begin
      index_reg <= block_index;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      cnt_reg <= 16'h0000;
    end else if (state_reg == ST_ERASE) begin
      cnt_reg <= cnt_reg + 16'h0001;
    end else begin
      cnt_reg <= 16'h0000;
    end
  end

  // A settings change anywhere during the pulse is remembered.
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      fail_seen_reg <= 1'b0;
    end else if (state_reg == ST_ERASE) begin
      fail_seen_reg <= fail_seen_reg | req_in.settings_changed;
    end else begin
      fail_seen_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      erase_en_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      erase_en_reg <= state_next == ST_ERASE;
      busy_reg <= state_next != ST_IDLE;
      done_reg <= state_next == ST_DONE;
    end
  end

  wire logic mem_wr = state_reg == ST_ERASE && cnt_last;

  fbe_block_state u_state (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .wr_en_in   (mem_wr),
    .wr_addr_in (index_reg[3:0]),
    .wr_data_in (~(fail_seen_reg | req_in.settings_changed)),
    .rd_addr_in (req_in.block_select[3:0]),
    .rd_data_out(block_erased_out)
  );

  assign erase_en_out = erase_en_reg;
  assign erase_block_out = index_reg[3:0];
  assign rsp_out.busy = busy_reg;
  assign rsp_out.done = done_reg;
  assign rsp_out.result = result_reg;

  wire logic res_fail = result_reg[fbe_pkg::RES_OVERALL_FAIL_BIT];
  wire logic res_bsel = result_reg[fbe_pkg::RES_BLOCK_SEL_ERR_BIT];
  wire logic res_key = result_reg[fbe_pkg::RES_KEY_ERR_BIT];
  wire logic res_exec = result_reg[fbe_pkg::RES_EXEC_ERR_BIT];
  wire logic res_prot = result_reg[fbe_pkg::RES_PROTECT_ERR_BIT];
  wire logic res_any = res_bsel | res_key | res_exec | res_prot;

  bit7_zero_a: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    !result_reg[fbe_pkg::RES_UNUSED_TOP_BIT])
    else $error("Result bit 7 not zero.");
  low_bits_zero_a: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    !result_reg[fbe_pkg::RES_UNUSED_HI_BIT]
    && !result_reg[fbe_pkg::RES_UNUSED_LO_BIT])
    else $error("Result bits 2..1 not zero.");
  range_no_erase_a: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    state_reg == ST_CHECK && range_err
    |=> (res_bsel && !erase_en_out) [*2])
    else $error("Bad block erased.");
  key_flag_a: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    state_reg == ST_CHECK |=> res_key == $past(key_err))
    else $error("Key error bit wrong.");
  protect_a: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    state_reg == ST_CHECK && prot_err |=> res_prot && !erase_en_out)
    else $error("Protect state not honoured.");
  boot_sel_a: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    state_reg == ST_CHECK && boot_sel |=> res_exec && !erase_en_out)
    else $error("Boot array select not refused.");
  fail_sum_a: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    done_reg |-> res_fail == res_any)
    else $error("Overall fail bit wrong.");
  clear_start_a: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    state_reg == ST_IDLE && req_in.start
    |=> result_reg == fbe_pkg::RESULT_CLEAR)
    else $error("Result not cleared.");
  one_block_a: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    erase_en_out && $past(erase_en_out) |-> $stable(erase_block_out))
    else $error("Block changed.");
  exec_err_a: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    state_reg == ST_ERASE && cnt_last && req_in.settings_changed
    |=> res_exec && res_fail)
    else $error("Execution error lost.");

  ok_cov_c: cover property (@(posedge clk_sys_in)
    done_reg && result_reg == 8'h00);
  range_cov_c: cover property (@(posedge clk_sys_in)
    done_reg && result_reg[3]);
  key_cov_c: cover property (@(posedge clk_sys_in)
    done_reg && result_reg[4]);
  exec_cov_c: cover property (@(posedge clk_sys_in)
    done_reg && res_exec);
endmodule

/* inc/fbe_pkg.sv */
// Package for the flash block-erase check block: parameter layouts, codes
// and timing. Assumes a 125 MHz system clock.
package fbe_pkg;

  localparam int unsigned CLK_MHZ = 125;
  // Erase pulse length in microseconds and its cycle count, rounded down.
  localparam int unsigned ERASE_TIME_US = 2;
  localparam int unsigned ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
  localparam logic [15:0] ERASE_CNT_LAST = 16'(ERASE_CYCLES - 1);

  localparam logic [7:0] KEY_UNLOCK = 8'h5a;
  localparam logic [7:0] ARRAY_SEL_USER_BOOT = 8'haa;
  // The block count conflicts between 16 and 24; this design accepts 16.
  localparam logic [7:0] LAST_BLOCK = 8'h0f;
  localparam int unsigned NUM_BLOCKS = 16;

  localparam int unsigned RES_OVERALL_FAIL_BIT = 0;
  localparam int unsigned RES_BLOCK_SEL_ERR_BIT = 3;
  localparam int unsigned RES_KEY_ERR_BIT = 4;
  localparam int unsigned RES_EXEC_ERR_BIT = 5;
  localparam int unsigned RES_PROTECT_ERR_BIT = 6;
  localparam int unsigned RES_UNUSED_TOP_BIT = 7;
  localparam int unsigned RES_UNUSED_HI_BIT = 2;
  localparam int unsigned RES_UNUSED_LO_BIT = 1;
  localparam logic [7:0] RESULT_CLEAR = 8'h00;

  typedef struct packed {
    logic        start;
    logic [31:0] block_select;
    logic [7:0]  flash_key;
    logic [7:0]  array_select;
    logic        error_protect_flag;
    logic        settings_changed;
  } fbe_req_type;

  typedef struct packed {
    logic       busy;
    logic       done;
    logic [7:0] result;
  } fbe_rsp_type;

endpackage

/* core/fbe_block_state.sv */
// Small per-block memory of erase state: one erased flag per block.
// Assumes use by the erase sequencer on the same clock, with separate write and read addresses.
`timescale 1ns/100ps
module fbe_block_state (
  input  wire logic       clk_sys_in,
  input  wire logic       nrst_in,
  input  wire logic       wr_en_in,
  input  wire logic [3:0] wr_addr_in,
  input  wire logic       wr_data_in,
  input  wire logic [3:0] rd_addr_in,
  output logic            rd_data_out
);
  logic [fbe_pkg::NUM_BLOCKS-1:0] mem_reg;

  genvar g;
  generate
    for (g = 0; g < fbe_pkg::NUM_BLOCKS; g++) begin : g_ent
      always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
          mem_reg[g] <= 1'b0;
        end else if (wr_en_in && wr_addr_in == 4'(g)) begin
          mem_reg[g] <= wr_data_in;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      rd_data_out <= 1'b0;
    end else begin
      rd_data_out <= mem_reg[rd_addr_in];
    end
  end
endmodule

/* dv/fbe_erase_check_tb.sv */
// Self-checking bench for the block-erase check sequencer.
// Assumes the design's own assertions run alongside; no separate model.
`timescale 1ns/100ps
module fbe_erase_check_tb;
  logic                 clk_sys_in;
  logic                 nrst_in;
  fbe_pkg::fbe_req_type req;
  fbe_pkg::fbe_rsp_type rsp;
  logic                 erase_en;
  logic [3:0]           erase_block;
  logic                 block_erased;
  int                   err_count = 0;
  int                   n_tests = 0;

  fbe_erase_check dut (
    .clk_sys_in       (clk_sys_in),
    .nrst_in          (nrst_in),
    .req_in           (req),
    .rsp_out          (rsp),
    .erase_en_out     (erase_en),
    .erase_block_out  (erase_block),
    .block_erased_out (block_erased)
  );

  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One erase request; on runs that reach the erase pulse a second start is pulsed mid-run and must be ignored.
  task automatic run(input logic [31:0] sel, input logic [7:0] key,
                     input logic [7:0] arr, input logic prot,
                     input logic sc, input logic [7:0] exp,
                     input logic erased);
    int n;
    int en_cnt;
    n = 0;
    en_cnt = 0;
    @(posedge clk_sys_in);
    req <= '{1'b1, sel, key, arr, prot, sc};
    @(posedge clk_sys_in);
    req.start <= 1'b0;
    #1;
    chk(rsp.busy, 1'b1, "busy after take");
    chk(rsp.result, 8'h00, "result cleared");
    while (rsp.done !== 1'b1 && n < 400) begin
      @(posedge clk_sys_in);
      req.start <= (n == 20);
      #1;
      n++;
      if (erase_en === 1'b1) begin
        en_cnt++;
        if (erase_block !== sel[3:0])
          chk(erase_block, sel[3:0], "block");
      end
    end
    chk(rsp.done, 1'b1, "done seen");
    chk(rsp.result, exp, "result word");
    if (exp == 8'h00 || sc)
      chk(en_cnt, fbe_pkg::ERASE_CYCLES, "erase length");
    else
      chk(en_cnt, 0, "no erase on refusal");
    @(posedge clk_sys_in);
    #1;
    chk({rsp.busy, rsp.done}, 2'b00, "idle after done");
    @(posedge clk_sys_in);
    #1;
    chk(block_erased, erased, "erased flag");
    chk(rsp.result, exp, "result stands");
  endtask

  initial begin
    #40000;
    err_count++;
    $display("wrong value at %0t: run timed out", $time);
    give_verdict();
  end

  initial begin
    nrst_in = 1'b0;
    req = '0;
    repeat (4) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    #1;
    chk({rsp.busy, rsp.done, erase_en}, 3'b000, "reset outputs");
    chk(rsp.result, 8'h00, "reset result");
    run(32'h0000_0000, 8'h5a, 8'h00, 1'b0, 1'b0, 8'h00, 1'b1);
    run(32'h0000_000f, 8'h5a, 8'h00, 1'b0, 1'b0, 8'h00, 1'b1);
    run(32'h0000_0010, 8'h5a, 8'h00, 1'b0, 1'b0, 8'h09, 1'b1);
    run(32'h0000_00ff, 8'h5a, 8'h00, 1'b0, 1'b0, 8'h09, 1'b1);
    run(32'h0000_0002, 8'h00, 8'h00, 1'b0, 1'b0, 8'h11, 1'b0);
    run(32'h0000_0002, 8'h5a, 8'h00, 1'b1, 1'b0, 8'h41, 1'b0);
    run(32'h0000_0002, 8'h5a, 8'haa, 1'b0, 1'b0, 8'h21, 1'b0);
    // Block 0 was erased earlier, so a failed pulse must clear its flag.
    run(32'h0000_0000, 8'h5a, 8'h00, 1'b0, 1'b1, 8'h21, 1'b0);
    run(32'h0000_0000, 8'h5a, 8'h00, 1'b0, 1'b0, 8'h00, 1'b1);
    run(32'habcd_0002, 8'h5a, 8'h00, 1'b0, 1'b0, 8'h00, 1'b1);
    give_verdict();
  end
endmodule
